/* File: shared_input_defines.vh */
// Offsets, field positions and reset values for the shared input block.
`ifndef SHARED_INPUT_DEFINES_VH
`define SHARED_INPUT_DEFINES_VH

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_EVENT_COUNT 8'h0C
`define OFS_AIS_BYTE    8'h10
`define OFS_RAIL        8'h14

`define CTRL_BUS_EN     0
`define CTRL_DS3E3      1
`define CTRL_DUAL_RAIL  2
`define CTRL_FALL_EDGE  3
`define CTRL_COUNT_EXZ  4
`define CTRL_WIDTH      5
`define CTRL_RESET      5'h00

`define ST_PATH_AIS     0
`define ST_LCV          1
`define ST_EXZ          2
`define ST_WIDTH        3
`define ST_RESET        3'h0

`define EXZ_RUN_DEFAULT 3
`define COUNT_WIDTH     16

`endif

/* File: edge_sync.v */
// Two-stage synchroniser with edge detection on the synchronised copy.
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta;
  reg [W-1:0] prev;

  // Only the second stage looks at the first stage; the history stage follows the second.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
      prev <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
      prev <= q;
    end
  end

  assign rise = q & ~prev;
  assign fall = ~q & prev;
endmodule
`default_nettype wire

/* File: shared_alarm_lcv_negrail_input.v */
// Shared alarm, line code violation and negative rail input of one channel.
//
// Contract
// - Bus enable selects the shared input role.
// - Sampled alarm high declares path AIS defect.
// - Bus disabled: channel mode selects the role.
// - STS-1 mode with bus off ignores input.
// - Single-rail: violation sampled on chosen clock edge.
// - Sampled violations or excess zeros bump counter.
// - Recovered clock times the receive framer path.
// - Add bus bytes taken on falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "shared_input_defines.vh"
module shared_alarm_lcv_negrail_input #(
  parameter EXZ_RUN = `EXZ_RUN_DEFAULT
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        add_bus_clock,
  input  wire [7:0]  add_bus_data_byte,
  input  wire        shared_alarm_pin,
  input  wire        rx_line_recovered_clock,
  input  wire        rx_line_positive_rail,
  output reg         path_ais_defect,
  output reg  [7:0]  add_bus_byte_out,
  output reg         add_bus_byte_valid,
  output reg         rx_line_sample_valid,
  output reg         rx_line_positive_out,
  output reg         rx_line_negative_out,
  output reg         rx_line_code_violation,
  output wire        irq
);
  localparam SW = 12;

  wire [SW-1:0] sync_q;
  wire [SW-1:0] sync_rise;
  wire [SW-1:0] sync_fall;

  edge_sync #(
    .W (SW)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({rx_line_positive_rail, shared_alarm_pin,
             rx_line_recovered_clock, add_bus_clock, add_bus_data_byte}),
    .q     (sync_q),
    .rise  (sync_rise),
    .fall  (sync_fall)
  );

  wire [7:0] data_s  = sync_q[7:0];
  wire       add_clk_fall = sync_fall[8];
  wire       rx_clk_rise  = sync_rise[9];
  wire       rx_clk_fall  = sync_fall[9];
  wire       shared_s     = sync_q[10];
  wire       pos_s        = sync_q[11];

  reg [`CTRL_WIDTH-1:0]  ctrl;
  reg [`ST_WIDTH-1:0]    status;
  reg [`ST_WIDTH-1:0]    mask;
  reg [`COUNT_WIDTH-1:0] event_count;
  reg [7:0]              ais_byte;
  reg [7:0]              zero_run;

  wire bus_en    = ctrl[`CTRL_BUS_EN];
  wire ds3e3     = ctrl[`CTRL_DS3E3];
  wire dual_rail = ctrl[`CTRL_DUAL_RAIL];
  wire fall_edge = ctrl[`CTRL_FALL_EDGE];
  wire count_exz = ctrl[`CTRL_COUNT_EXZ];

  // Role decode of the shared pin.
  wire role_alarm = bus_en;
  wire role_lcv   = !bus_en && ds3e3 && !dual_rail;
  wire role_neg   = !bus_en && ds3e3 && dual_rail;

  // Recovered clock edge chosen by configuration drives the receive path.
  wire rx_edge = !bus_en && (fall_edge ? rx_clk_fall : rx_clk_rise);

  // A byte is accepted on each falling edge of the add bus clock while the bus is enabled.
  wire add_take = bus_en && add_clk_fall;

  // The source is trusted to strobe only on AIS bytes, so any high sample
  // on an accepted byte declares the defect.
  wire ais_event = add_take && shared_s;

  // In STS-1 mode with the bus off the pin has no role and its level never reaches logic.
  wire lcv_sample = rx_edge && role_lcv && shared_s;

  wire [7:0] next_zero_run = (rx_edge && !pos_s) ?
                             ((zero_run == 8'hFF) ? zero_run :
                              zero_run + 8'h01) :
                             (rx_edge ? 8'h00 : zero_run);
  wire exz_event = rx_edge && role_lcv && !pos_s &&
                   (next_zero_run == EXZ_RUN[7:0]);

  // Receive framer outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line_sample_valid   <= 1'b0;
      rx_line_positive_out   <= 1'b0;
      rx_line_negative_out   <= 1'b0;
      rx_line_code_violation <= 1'b0;
      zero_run               <= 8'h00;
    end else begin
      rx_line_sample_valid   <= rx_edge;
      zero_run               <= next_zero_run;
      rx_line_code_violation <= lcv_sample;
      if (rx_edge) begin
        // Positive rail holds all data unless dual-rail is chosen.
        rx_line_positive_out <= pos_s;
        // The negative rail is taken only in dual-rail operation.
        rx_line_negative_out <= role_neg & shared_s;
      end
    end
  end

  // Add bus outputs and AIS byte capture.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_bus_byte_out   <= 8'h00;
      add_bus_byte_valid <= 1'b0;
      path_ais_defect    <= 1'b0;
      ais_byte           <= 8'h00;
    end else begin
      add_bus_byte_valid <= add_take;
      if (add_take) begin
        add_bus_byte_out <= data_s;
        // Low on a byte means no AIS indication for that byte.
        path_ais_defect  <= shared_s;
      end else if (!bus_en) begin
        path_ais_defect  <= 1'b0;
      end
      if (ais_event) begin
        ais_byte <= data_s;
      end
    end
  end

  // Event counter picks violations or excessive zeros, saturating.
  wire count_hit = count_exz ? exz_event : lcv_sample;

  // APB access decode.
  wire wr_access = psel && penable && pwrite;
  wire setup     = psel && !penable;
  wire [`ST_WIDTH-1:0] w1c = (wr_access && paddr == `OFS_STATUS) ?
                             pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};
  wire [`ST_WIDTH-1:0] set_bits = {exz_event, lcv_sample, ais_event};
  // A new event in the clearing cycle survives the clear.
  wire [`ST_WIDTH-1:0] next_status = (status & ~w1c) | set_bits;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= `CTRL_RESET;
      mask        <= `ST_RESET;
      status      <= `ST_RESET;
      event_count <= {`COUNT_WIDTH{1'b0}};
    end else begin
      status <= next_status;
      if (wr_access && paddr == `OFS_CTRL) begin
        // New settings steer only samples taken after this write.
        ctrl <= pwdata[`CTRL_WIDTH-1:0];
      end
      if (wr_access && paddr == `OFS_MASK) begin
        mask <= pwdata[`ST_WIDTH-1:0];
      end
      if (wr_access && paddr == `OFS_EVENT_COUNT) begin
        event_count <= {`COUNT_WIDTH{1'b0}};
      end else if (count_hit && event_count != {`COUNT_WIDTH{1'b1}}) begin
        event_count <= event_count + {{(`COUNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Read data is staged in the setup cycle so that it comes from a flop
  // while still answering with no wait state.
  reg [31:0] next_rdata;
  reg        next_err;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr)
      `OFS_CTRL:        next_rdata[`CTRL_WIDTH-1:0] = ctrl;
      `OFS_STATUS:      next_rdata[`ST_WIDTH-1:0]   = status;
      `OFS_MASK:        next_rdata[`ST_WIDTH-1:0]   = mask;
      `OFS_EVENT_COUNT: next_rdata[`COUNT_WIDTH-1:0] = event_count;
      `OFS_AIS_BYTE:    next_rdata[7:0] = ais_byte;
      `OFS_RAIL: begin
        next_rdata[0] = rx_line_positive_out;
        next_rdata[1] = rx_line_negative_out;
        next_rdata[2] = path_ais_defect;
        next_rdata[3] = role_alarm;
        next_rdata[4] = role_lcv;
        next_rdata[5] = role_neg;
      end
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
  end

  assign pready = 1'b1;
  assign irq    = |(status & mask);
endmodule
`default_nettype wire

/* File: shared_input_props.sv */
// Port checks for the shared alarm input block.
`timescale 1ns/1ps
`default_nettype none
module shared_input_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        add_bus_clock,
  input wire logic        rx_line_recovered_clock,
  input wire logic        path_ais_defect,
  input wire logic        add_bus_byte_valid,
  input wire logic        rx_line_sample_valid,
  input wire logic        rx_line_negative_out,
  input wire logic        rx_line_code_violation
);
  logic [4:0] c;
  // The control word is shadowed from write traffic, as no port shows it.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c <= 5'h00;
    else if (psel && penable && pwrite && paddr == 8'h00) c <= pwdata[4:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  byte_bus_a: assert property (add_bus_byte_valid |-> c[0])
    else $error("byte with bus off");
  rx_off_a: assert property (rx_line_sample_valid |-> !c[0])
    else $error("sample with bus on");
  defect_off_a: assert property (!c[0] && !$past(c[0]) |->
    !path_ais_defect) else $error("defect with bus off");
  sts_quiet_a: assert property (rx_line_sample_valid && !c[1] |->
    !rx_line_negative_out && !rx_line_code_violation) else $error("not ignored");
  lcv_role_a: assert property (rx_line_code_violation |->
    rx_line_sample_valid && c[2:0] == 3'b010) else $error("violation role");
  lcv_pulse_a: assert property (rx_line_code_violation |=>
    !rx_line_code_violation) else $error("violation too long");
  byte_take_a: assert property ($fell(add_bus_clock) && c[0] |->
    ##[1:5] add_bus_byte_valid) else $error("byte missed");
  rx_take_a: assert property (!c[0] &&
    (c[3] ? $fell(rx_line_recovered_clock) : $rose(rx_line_recovered_clock))
    |-> ##[1:5] rx_line_sample_valid) else $error("line edge missed");
endmodule
bind shared_alarm_lcv_negrail_input shared_input_props i_props (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .add_bus_clock,
  .rx_line_recovered_clock, .path_ais_defect, .add_bus_byte_valid,
  .rx_line_sample_valid, .rx_line_negative_out, .rx_line_code_violation);
`default_nettype wire

/* File: link_far_end.sv */
// Far-end model: add bus source and line interface unit on one clock.
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
  input  wire logic       run,
  input  wire logic       upd_fall,
  input  wire logic [9:0] rnd,
  output logic            lclk,
  output logic [7:0]      byte_d,
  output logic            pin,
  output logic            pos
);
  initial begin
    lclk = 1'b0;
    #7;
    forever begin
      #160;
      if (run || lclk) lclk = ~lclk;
    end
  end
  // Data moves only at the edge opposite the sampling one, so it is steady
  // for a whole period around every sample.
  always @(lclk) if (lclk != upd_fall) {byte_d, pin, pos} = rnd;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the shared alarm input block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run = 1'b0, rise = 1'b0, lclk, pin, pos;
  logic pready, pslverr, irq, abv, dfc, rsv, rpo, rno, lcv;
  logic [7:0] paddr = '0, byte_d, bo;
  logic [31:0] pwdata = '0, prdata, seed = 32'ha9c6_9c3e;
  logic [9:0] rnd = '0, e, q[$];
  logic [4:0] m = '0;
  logic [32:0] d;
  int error_cnt = 0, tests_run = 0, n = 0, ais = 0, z = 0, x = 0;
  always #20 pclk = ~pclk;
  shared_alarm_lcv_negrail_input i_shared_alarm_lcv_negrail_input (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .add_bus_clock(lclk), .add_bus_data_byte(byte_d),
    .shared_alarm_pin(pin), .rx_line_recovered_clock(lclk),
    .rx_line_positive_rail(pos), .path_ais_defect(dfc),
    .add_bus_byte_out(bo), .add_bus_byte_valid(abv),
    .rx_line_sample_valid(rsv), .rx_line_positive_out(rpo),
    .rx_line_negative_out(rno), .rx_line_code_violation(lcv), .irq);
  link_far_end i_link_far_end (.run, .upd_fall(rise), .rnd, .lclk, .byte_d,
    .pin, .pos);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  always @(posedge pclk) begin
    seed <= xs(seed);
    rnd <= seed[9:0];
  end
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [32:0] r);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      error_cnt++;
      final_report;
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Each sampling edge notes what the block must report for it.
  always @(lclk) if (lclk == rise) q.push_back({byte_d, pin, pos});
  always @(negedge pclk) if (abv || rsv) begin
    if (q.size() == 0) chk(0, 1);
    else begin
      e = q.pop_front();
      if (m[0]) chk({bo, dfc}, e[9:1]);
      else chk({rpo, rno, lcv}, {e[0], m[2] & e[1],
        (m[2:1] == 2'b01) & e[1]});
      n += int'((m[2:1] == 2'b01) & e[1]);
      // Zero run on the positive rail, tracked over every receive sample.
      if (!m[0]) z = e[0] ? 0 : ((z < 255) ? z + 1 : z);
      x += int'(!m[0] && m[4] && m[2:1] == 2'b01 && z == 3);
      ais |= int'(m[0] & e[1]);
    end
  end
  // Link clock stops between modes so no sample straddles a mode change.
  task automatic phase(input logic [4:0] c);
    apb(1'b1, 8'h00, 32'(c), d);
    q.delete();
    m = c;
    rise <= !c[0] && !c[3];
    @(posedge pclk);
    run <= 1'b1;
    repeat (400) @(posedge pclk);
    run <= 1'b0;
    repeat (24) @(posedge pclk);
    chk(q.size(), 0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, d);
      chk(d, 0);
    end
    apb(1'b0, 8'h20, 32'h0, d);
    chk(d, 33'h1_0000_0000);
    phase(5'h01);
    chk(irq, 0);
    apb(1'b1, 8'h08, 32'h1, d);
    chk(irq, ais);
    apb(1'b1, 8'h04, 32'h1, d);
    apb(1'b0, 8'h04, 32'h0, d);
    chk({irq, d[31:0]}, 0);
    apb(1'b1, 8'h0C, 32'h0, d);
    phase(5'h00);
    phase(5'h02);
    phase(5'h0A);
    apb(1'b0, 8'h0C, 32'h0, d);
    chk(d, n);
    phase(5'h06);
    apb(1'b1, 8'h0C, 32'h0, d);
    phase(5'h12);
    apb(1'b0, 8'h0C, 32'h0, d);
    chk(d, x);
    final_report;
  end
endmodule
`default_nettype wire
